/* tb/fbrp_master_model.sv */
// bus master model that issues burst reads and gathers returned words
`timescale 1ns/100ps
module fbrp_master_model (
   input wire logic ref_clk,
   output logic [11:0] addr,
   output logic read,
   output logic [7:0] cnt,
   input wire logic waitrequest,
   input wire logic [31:0] rdata,
   input wire logic rvalid
);
   logic [31:0] got[$];
   int timeouts = 0;
   initial begin
      read = 1'b0;
      addr = 12'hFFF;
      cnt = 8'h00;
   end
   always @(posedge ref_clk) begin
      if (rvalid === 1'b1) begin
         got.push_back(rdata);
      end
   end
   // call just after a rising edge; gap cycles let the master run slowly
   task automatic burst(input logic [11:0] a, input logic [7:0] n, input int gap);
      int i;
      repeat (gap) @(posedge ref_clk);
      read <= 1'b1;
      addr <= a;
      cnt <= n;
      i = 0;
      // command held until waitrequest is sampled low
      do begin
         @(posedge ref_clk);
         i++;
      end while (waitrequest !== 1'b0 && i < 400);
      read <= 1'b0;
      // released lines show inverted values, not the old command
      addr <= ~a;
      cnt <= ~n;
      if (i >= 400) timeouts++;
   endtask
endmodule // fbrp_master_model

/* tb/flash_burst_read_port_bench.sv */
// testbench for the flash burst read port
`timescale 1ns/100ps
module flash_burst_read_port_bench;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic load_en = 1'b0;
   logic erase_req = 1'b0;
   logic [11:0] load_addr = 12'h000;
   logic [31:0] load_data = 32'h00000000;
   logic [1:0] sector_protect = 2'h0;
   logic [1:0] hidden_req = 2'h0;
   logic [11:0] a_i, a_w;
   logic [7:0] c_i, c_w;
   logic [31:0] rd_i, rd_w;
   logic r_i, r_w, wr_i, wr_w, v_i, v_w;
   logic [1:0] hg;
   logic [4:0] st_i, st_w;
   int n_fail = 0;
   int check_count = 0;
   bit erased = 0;
   always #12.5 ref_clk = ~ref_clk;
   fbrp_port #(.BURST_PARAM(8)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .data_addr(a_i),
      .data_read(r_i), .data_burstcount(c_i), .data_waitrequest(wr_i), .data_readdata(rd_i),
      .data_readdatavalid(v_i), .load_addr(load_addr), .load_en(load_en), .load_data(load_data),
      .erase_req(erase_req), .sector_protect(sector_protect), .hidden_req(hidden_req),
      .hidden_granted(hg), .status(st_i));
   fbrp_port #(.WRAP_MODE(1'b1), .BURST_PARAM(4)) dut_wrap (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .data_addr(a_w), .data_read(r_w), .data_burstcount(c_w),
      .data_waitrequest(wr_w), .data_readdata(rd_w), .data_readdatavalid(v_w),
      .load_addr(load_addr), .load_en(load_en), .load_data(load_data), .erase_req(erase_req),
      .sector_protect(sector_protect), .hidden_req(hidden_req), .hidden_granted(),
      .status(st_w));
   fbrp_master_model m_inc (.ref_clk(ref_clk), .addr(a_i), .read(r_i), .cnt(c_i),
      .waitrequest(wr_i), .rdata(rd_i), .rvalid(v_i));
   fbrp_master_model m_wrap (.ref_clk(ref_clk), .addr(a_w), .read(r_w), .cnt(c_w),
      .waitrequest(wr_w), .rdata(rd_w), .rvalid(v_w));
   // only the first and last eight words carry content
   function automatic logic [31:0] expw(input logic [11:0] a);
      if (!erased && (a < 12'h008 || a >= 12'hFF8)) return 32'hC0DE0000 + {20'h00000, a};
      return fbrp_pkg::FBRP_BLANK;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic run_burst(input bit w, input logic [11:0] a, input logic [7:0] n,
      input int nexp, input bit bad);
      int k;
      logic [11:0] x;
      logic [4:0] st;
      if (w) m_wrap.burst(a, n, 0);
      else m_inc.burst(a, n, 0);
      // busy reaches the status two edges after the take
      repeat (2) @(posedge ref_clk);
      #1;
      chk(w ? st_w[1:0] : st_i[1:0], fbrp_pkg::FBRP_BUSY_READ);
      k = 0;
      while ((w ? m_wrap.got.size() : m_inc.got.size()) < nexp && k < 600) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 600 || m_inc.timeouts + m_wrap.timeouts > 0) begin
         n_fail++;
         stop_test();
      end
      repeat (4) @(posedge ref_clk);
      chk(w ? m_wrap.got.size() : m_inc.got.size(), nexp);
      for (k = 0; k < nexp; k++) begin
         x = w ? {a[11:2], a[1:0] + k[1:0]} : a + k[11:0];
         chk(w ? m_wrap.got.pop_front() : m_inc.got.pop_front(),
            bad ? fbrp_pkg::FBRP_BLANK : expw(x));
      end
      st = w ? st_w : st_i;
      chk(st[fbrp_pkg::FBRP_BIT_RD_OK], !bad);
      if (bad) chk(st[fbrp_pkg::FBRP_BIT_EMPTY], 1'b1);
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      chk(wr_i, 1'b1);
      sys_rst <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         load_en <= 1'b1;
         load_addr <= (i < 8) ? i[11:0] : 12'hFF0 + i[11:0];
         load_data <= 32'hC0DE0000 + ((i < 8) ? i : 32'hFF0 + i);
      end
      @(posedge ref_clk);
      load_en <= 1'b0;
      hidden_req <= 2'h3;
      repeat (3) @(posedge ref_clk);
      chk(hg[0], 1'b0);
      run_burst(0, 12'h000, 8, 8, 0);
      run_burst(0, 12'h003, 2, 2, 0);
      run_burst(0, 12'hFFE, 4, 4, 0);
      run_burst(0, 12'h100, 1, 1, 0);
      run_burst(0, 12'h000, 9, 1, 1);
      run_burst(1, 12'h002, 4, 4, 0);
      run_burst(1, 12'hFFD, 4, 4, 0);
      sector_protect <= 2'h1;
      run_burst(0, 12'h005, 1, 1, 1);
      sector_protect <= 2'h0;
      erase_req <= 1'b1;
      @(posedge ref_clk);
      erase_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(st_i[1:0], fbrp_pkg::FBRP_BUSY_ERASE);
      chk(wr_i, 1'b1);
      erased = 1;
      @(posedge ref_clk);
      run_burst(0, 12'h000, 2, 2, 0);
      stop_test();
   end
endmodule // flash_burst_read_port_bench

/* verilog/fbrp_flash_array.sv */
// module: flash storage array with blank fill and one-cycle read
`timescale 1ns/100ps
module fbrp_flash_array #(
   parameter int DEPTH = 4096,
   parameter int AW = fbrp_pkg::FBRP_ADDR_W,
   parameter int INIT_WORDS = 0
) (
   input wire logic ref_clk,
   input wire logic [AW-1:0] rd_addr,
   input wire logic [AW-1:0] wr_addr,
   input wire logic wr_en,
   input wire logic [31:0] wr_data,
   input wire logic erase_all,
   output logic [31:0] rd_data
);
   logic [31:0] mem [DEPTH];
   // unloaded words read blank; content past the array is dropped
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = fbrp_pkg::FBRP_BLANK;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (erase_all) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= fbrp_pkg::FBRP_BLANK;
         end
      end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
         mem[wr_addr] <= wr_data;
      end
   end
   always_ff @(posedge ref_clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule // fbrp_flash_array

/* verilog/fbrp_pkg.sv */
// package: constants and types for the flash burst read port
package fbrp_pkg;
   localparam int FBRP_DATA_W = 32;
   localparam int FBRP_ADDR_W = 12;
   localparam int FBRP_MAX_INCR_BURST = 128;
   localparam int FBRP_WRAP_LEN_BUS64 = 2;
   localparam int FBRP_WRAP_LEN_BUS128 = 4;
   localparam int FBRP_DEF_BURST = 2;
   localparam int FBRP_CNT_W = 8;
   localparam logic [1:0] FBRP_BUSY_IDLE = 2'h0;
   localparam logic [1:0] FBRP_BUSY_ERASE = 2'h1;
   localparam logic [1:0] FBRP_BUSY_READ = 2'h3;
   localparam logic [31:0] FBRP_BLANK = 32'hFFFFFFFF;
   localparam int FBRP_BIT_BUSY_LO = 0;
   localparam int FBRP_BIT_RD_OK = 2;
   localparam int FBRP_BIT_EMPTY = 3;
   localparam int FBRP_BIT_ERASE_OK = 4;
   localparam int FBRP_STAT_W = 5;
   localparam real FBRP_CLK_MHZ = 40.0;
   localparam real FBRP_MAX_PAR_MHZ = 116.0;
   localparam real FBRP_MAX_SER_MHZ = 7.25;
   typedef enum logic [2:0] {
      FBRP_IDLE = 3'b001,
      FBRP_FETCH = 3'b010,
      FBRP_ERASE = 3'b100
   } fbrp_state_t;
endpackage

/* verilog/fbrp_port.sv */
// module: burst read port of the user flash controller
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module fbrp_port #(
   parameter bit SERIAL = 1'b0,
   parameter bit WRAP_MODE = 1'b0,
   parameter bit BUS128 = 1'b1,
   parameter int BURST_PARAM = fbrp_pkg::FBRP_DEF_BURST,
   parameter bit SINGLE_UNCOMP = 1'b1,
   parameter int USER_WORDS = 3072,
   parameter int CFG2_WORDS = 1024,
   parameter int ERASE_CYCLES = 16
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [fbrp_pkg::FBRP_ADDR_W-1:0] data_addr,
   input wire logic data_read,
   input wire logic [fbrp_pkg::FBRP_CNT_W-1:0] data_burstcount,
   output logic data_waitrequest,
   output logic [31:0] data_readdata,
   output logic data_readdatavalid,
   input wire logic [fbrp_pkg::FBRP_ADDR_W-1:0] load_addr,
   input wire logic load_en,
   input wire logic [31:0] load_data,
   input wire logic erase_req,
   input wire logic [1:0] sector_protect,
   input wire logic [1:0] hidden_req,
   output logic [1:0] hidden_granted,
   output logic [fbrp_pkg::FBRP_STAT_W-1:0] status
);
   localparam int AW = fbrp_pkg::FBRP_ADDR_W;
   localparam int CW = fbrp_pkg::FBRP_CNT_W;
   localparam int TOTAL = USER_WORDS + (SINGLE_UNCOMP ? CFG2_WORDS : 0);
   localparam int WLEN = BUS128 ? fbrp_pkg::FBRP_WRAP_LEN_BUS128 :
      fbrp_pkg::FBRP_WRAP_LEN_BUS64;
   localparam logic [AW-1:0] WMASK = AW'(WLEN - 1);

   initial begin
      if (!(BURST_PARAM == 2 || BURST_PARAM == 4 || BURST_PARAM == 8 ||
            BURST_PARAM == fbrp_pkg::FBRP_MAX_INCR_BURST)) begin
         $error("burst parameter must be 2, 4, 8 or 128");
      end
      if (SERIAL && WRAP_MODE) begin
         $error("wrapping bursts need the parallel port");
      end
      if (TOTAL > (1 << AW)) begin
         $error("flash larger than address space");
      end
      if (fbrp_pkg::FBRP_CLK_MHZ > (SERIAL ? fbrp_pkg::FBRP_MAX_SER_MHZ :
                                    fbrp_pkg::FBRP_MAX_PAR_MHZ)) begin
         $error("clock too fast for port type");
      end
   end

   fbrp_pkg::fbrp_state_t state;
   logic [AW-1:0] cur_addr;
   logic [AW-1:0] base_addr;
   logic [CW-1:0] remain;
   logic fail;
   logic fetch_pend;
   logic [15:0] erase_cnt;
   logic [1:0] busy;
   logic rd_ok;
   logic empty;
   logic [31:0] arr_data;
   logic [AW-1:0] next_addr;
   logic [CW-1:0] req_len;
   logic req_legal;
   logic addr_bad;
   logic cmd_take;

   // serial ports stream a fixed word count; wrap uses the fixed length
   always_comb begin
      if (SERIAL) begin
         req_len = CW'(BURST_PARAM);
      end else if (WRAP_MODE) begin
         req_len = CW'(WLEN);
      end else begin
         req_len = data_burstcount;
      end
   end
   // on the parallel incrementing port a count of zero or above the parameter is refused as a fail read
   assign req_legal = SERIAL || (WRAP_MODE ? (data_burstcount == CW'(WLEN)) :
      (data_burstcount != '0 && int'(data_burstcount) <= BURST_PARAM));
   assign addr_bad = (int'(data_addr) >= TOTAL) || (data_addr < AW'(USER_WORDS) ?
      sector_protect[0] : sector_protect[1]);
   // only taken while waitrequest is low, so a held command is never taken twice
   assign cmd_take = (state == fbrp_pkg::FBRP_IDLE) && data_read && !erase_req &&
      !data_waitrequest;

   always_comb begin
      if (WRAP_MODE) begin
         next_addr = (cur_addr & ~WMASK) | ((cur_addr + AW'(1)) & WMASK);
      end else if (int'(cur_addr) + 1 >= TOTAL) begin
         next_addr = '0;
      end else begin
         next_addr = cur_addr + AW'(1);
      end
   end

   fbrp_flash_array #(
      .DEPTH(TOTAL),
      .AW(AW),
      .INIT_WORDS(0)
   ) u_array (
      .ref_clk(ref_clk),
      .rd_addr(cur_addr),
      .wr_addr(load_addr),
      .wr_en(load_en),
      .wr_data(load_data),
      .erase_all(state == fbrp_pkg::FBRP_ERASE && erase_cnt == 16'h0001),
      .rd_data(arr_data)
   );

   // state machine: idle takes a command, fetch streams words, erase stalls
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= fbrp_pkg::FBRP_IDLE;
         cur_addr <= '0;
         base_addr <= '0;
         remain <= '0;
         fail <= 1'b0;
         fetch_pend <= 1'b0;
         erase_cnt <= '0;
      end else begin
         case (state)
            fbrp_pkg::FBRP_IDLE: begin
               fetch_pend <= 1'b0;
               if (erase_req) begin
                  state <= fbrp_pkg::FBRP_ERASE;
                  erase_cnt <= 16'(ERASE_CYCLES);
               end else if (cmd_take) begin
                  state <= fbrp_pkg::FBRP_FETCH;
                  cur_addr <= data_addr;
                  base_addr <= data_addr;
                  remain <= req_legal ? req_len : CW'(1);
                  fail <= addr_bad || !req_legal;
               end
            end
            fbrp_pkg::FBRP_FETCH: begin
               // one word per cycle; array read is one cycle behind the address
               fetch_pend <= (remain != '0);
               if (remain != '0) begin
                  remain <= remain - CW'(1);
                  cur_addr <= next_addr;
               end else if (!fetch_pend) begin
                  state <= fbrp_pkg::FBRP_IDLE;
               end
            end
            fbrp_pkg::FBRP_ERASE: begin
               erase_cnt <= erase_cnt - 16'h0001;
               if (erase_cnt == 16'h0001) begin
                  state <= fbrp_pkg::FBRP_IDLE;
               end
            end
            default: state <= fbrp_pkg::FBRP_IDLE;
         endcase
      end
   end

   // stall unless idle with no erase starting; hold the command meanwhile
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         data_waitrequest <= 1'b1;
      end else begin
         data_waitrequest <= !(state == fbrp_pkg::FBRP_IDLE && !erase_req &&
            !(data_read && data_waitrequest == 1'b0));
      end
   end

   // returned words in address order, the count asked; a refused count returns one word
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         data_readdata <= '0;
         data_readdatavalid <= 1'b0;
      end else begin
         data_readdatavalid <= fetch_pend;
         data_readdata <= fail ? fbrp_pkg::FBRP_BLANK : arr_data;
      end
   end

   // status: busy code, read success and the empty flag set on a failed read
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy <= fbrp_pkg::FBRP_BUSY_IDLE;
         rd_ok <= 1'b0;
         empty <= 1'b0;
      end else begin
         if (state == fbrp_pkg::FBRP_FETCH) begin
            busy <= fbrp_pkg::FBRP_BUSY_READ;
         end else if (state == fbrp_pkg::FBRP_ERASE) begin
            busy <= fbrp_pkg::FBRP_BUSY_ERASE;
         end else begin
            busy <= fbrp_pkg::FBRP_BUSY_IDLE;
         end
         if (state == fbrp_pkg::FBRP_FETCH && remain == '0 && !fetch_pend) begin
            rd_ok <= !fail;
            empty <= fail;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         status <= '0;
         hidden_granted <= 2'h0;
      end else begin
         status <= {1'b0, empty, rd_ok, busy};
         // user sector never gets hidden mode
         hidden_granted <= {hidden_req[1], 1'b0};
      end
   end

   a_busy_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state == fbrp_pkg::FBRP_FETCH |=> busy == fbrp_pkg::FBRP_BUSY_READ)
      else $error("busy not read code");
   a_valid_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cmd_take && req_legal && req_len == CW'(2) && !data_waitrequest) |->
      ##3 data_readdatavalid ##1 data_readdatavalid ##1 !data_readdatavalid)
      else $error("wrong word count");
   a_erase_stall: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state == fbrp_pkg::FBRP_ERASE |=> data_waitrequest)
      else $error("erase did not stall");
   a_fail_empty: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(empty) |-> !rd_ok)
      else $error("empty with success");
   a_ok_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(rd_ok) |-> !fail)
      else $error("success on failed read");
   a_wrap_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (WRAP_MODE && state == fbrp_pkg::FBRP_FETCH) |->
      ((cur_addr & ~WMASK) == (base_addr & ~WMASK)))
      else $error("wrap left block");
   a_stall_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state == fbrp_pkg::FBRP_FETCH |=> data_waitrequest)
      else $error("accepted while busy");
   a_hidden_user: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !hidden_granted[0])
      else $error("hidden on user sector");

   // helper: words returned in this burst against words asked
   logic [CW-1:0] words_seen;
   logic [CW-1:0] words_asked;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         words_seen <= '0;
         words_asked <= '0;
      end else if (cmd_take) begin
         words_seen <= '0;
         words_asked <= req_legal ? req_len : CW'(1);
      end else if (data_readdatavalid) begin
         words_seen <= words_seen + CW'(1);
      end
   end

   a_count_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
      data_readdatavalid |-> (words_seen < words_asked))
      else $error("more words than asked");

   a_count_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == fbrp_pkg::FBRP_FETCH && remain == '0 && !fetch_pend) |=>
      (words_seen == words_asked))
      else $error("burst ended short");

   a_valid_burst: assert property (@(posedge ref_clk) disable iff (sys_rst)
      data_readdatavalid |-> (state == fbrp_pkg::FBRP_FETCH))
      else $error("valid outside a burst");

   a_fail_blank: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (data_readdatavalid && fail) |-> (data_readdata == fbrp_pkg::FBRP_BLANK))
      else $error("failed read not blank");

   a_wrap_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (WRAP_MODE && cmd_take && req_legal) |=> (remain == CW'(WLEN)))
      else $error("wrap length wrong");

   a_take_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cmd_take |-> !data_waitrequest)
      else $error("taken while stalled");

   a_addr_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!WRAP_MODE && state == fbrp_pkg::FBRP_FETCH && remain != '0 &&
      int'(cur_addr) + 1 < TOTAL) |=> (cur_addr == $past(cur_addr) + AW'(1)))
      else $error("address did not step");

   a_end_wrap: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!WRAP_MODE && state == fbrp_pkg::FBRP_FETCH && remain != '0 &&
      int'(cur_addr) == TOTAL - 1) |=> (cur_addr == '0))
      else $error("no wrap at flash end");

   a_ok_status: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(rd_ok) |=> status[fbrp_pkg::FBRP_BIT_RD_OK])
      else $error("success not in status");

   a_busy_status: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (busy == fbrp_pkg::FBRP_BUSY_READ) |=> (status[1:0] == fbrp_pkg::FBRP_BUSY_READ))
      else $error("busy code not in status");

   a_erase_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == fbrp_pkg::FBRP_ERASE) |=> (busy == fbrp_pkg::FBRP_BUSY_ERASE))
      else $error("erase code missing");

   // spare bit kept low; erase result is not modelled here
   a_spare_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !status[fbrp_pkg::FBRP_BIT_ERASE_OK])
      else $error("spare status bit set");

   a_hidden_cfg: assert property (@(posedge ref_clk) disable iff (sys_rst)
      hidden_req[1] |=> hidden_granted[1])
      else $error("config hidden not granted");
endmodule // fbrp_port
